// [hdl/cfgp_top.sv]
`timescale 1ns/1ps

module cfgp_top
   import cfgp_pkg::*;
(
   // clock, reset, enable
   input  wire logic                  CORE_CLK,
   input  wire logic                  RESET,
   input  wire logic                  CLK_EN,
   // configuration pins
   input  wire logic                  INTERFACE_SELECT_PIN,
   input  wire logic                  CS_N,
   input  wire logic                  SCK,
   input  wire logic                  SDI,
   output logic                       SDO_O,
   output logic                       SDO_OE,
   // decoded modes
   output logic                       DCS_ON,
   output logic                       SLEEP_ON,
   output logic                       NAP_ON,
   output logic                       LVDS_LOW_CURRENT,
   // raw mode registers
   output logic [DATA_BITS-1:0]       POWER_DOWN_CTRL,
   output logic [DATA_BITS-1:0]       TIMING_CTRL,
   output logic [DATA_BITS-1:0]       OUTPUT_CTRL,
   output logic [DATA_BITS-1:0]       FORMAT_CTRL
);

   ////////////////////////////////////////////////////////////////////////
   // pin sampling and frame capture

   cfgp_link_if link ();

   logic                       fr_active;
   logic                       fr_hdr;
   logic                       fr_word;
   logic [CNT_BITS-1:0]        fr_cnt;
   logic [WORD_BITS-1:0]       fr_data;

   cfgp_sync u_sync (
      .clk     (CORE_CLK),
      .rst     (RESET),
      .en      (CLK_EN),
      .if_sel  (INTERFACE_SELECT_PIN),
      .cs_n    (CS_N),
      .sck     (SCK),
      .sdi     (SDI),
      .link    (link.src)
   );

   cfgp_frame u_frame (
      .clk      (CORE_CLK),
      .rst      (RESET),
      .en       (CLK_EN),
      .link     (link.dst),
      .active   (fr_active),
      .hdr_stb  (fr_hdr),
      .word_stb (fr_word),
      .bit_cnt  (fr_cnt),
      .word     (fr_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode registers

   logic [DATA_BITS-1:0] mode_reg  [1:NUM_MODE_REGS-1];
   logic [DATA_BITS-1:0] mode_next [1:NUM_MODE_REGS-1];
   logic                 srst_reg, srst_next;
   logic                 wr_cmd;
   logic [ADDR_BITS-1:0] wr_addr;
   logic [DATA_BITS-1:0] wr_data;

   // address 00h and unmapped addresses read as zero
   function automatic logic [DATA_BITS-1:0] read_mode(
      input logic [ADDR_BITS-1:0] a
   );
      logic [DATA_BITS-1:0] v;
      v = READ_ZERO;
      for (int k = 1; k < NUM_MODE_REGS; k++) begin
         if (a == ADDR_BITS'(k)) begin
            v = mode_reg[k];
         end
      end
      return v;
   endfunction

   assign wr_cmd  = fr_word & ~fr_data[RW_POS];
   assign wr_addr = fr_data[RW_POS-1:DATA_BITS];
   assign wr_data = fr_data[DATA_BITS-1:0];

   always_comb begin
      for (int k = 1; k < NUM_MODE_REGS; k++) begin
         mode_next[k] = mode_reg[k];
      end
      srst_next = 1'b0;
      if (srst_reg) begin
         for (int k = 1; k < NUM_MODE_REGS; k++) begin
            mode_next[k] = MODE_REG_RESET;
         end
      end else if (wr_cmd) begin
         if (wr_addr == ADDR_SOFT_RESET) begin
            srst_next = wr_data[SOFT_RESET_BIT];
         end else begin
            for (int k = 1; k < NUM_MODE_REGS; k++) begin
               if (wr_addr == ADDR_BITS'(k)) begin
                  mode_next[k] = wr_data;
               end
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         for (int k = 1; k < NUM_MODE_REGS; k++) begin
            mode_reg[k] <= MODE_REG_RESET;
         end
         srst_reg <= 1'b0;
      end else if (CLK_EN) begin
         for (int k = 1; k < NUM_MODE_REGS; k++) begin
            mode_reg[k] <= mode_next[k];
         end
         srst_reg <= srst_next;
      end
   end

   assign POWER_DOWN_CTRL = mode_reg[ADDR_POWER_DOWN];
   assign TIMING_CTRL     = mode_reg[ADDR_TIMING];
   assign OUTPUT_CTRL     = mode_reg[ADDR_OUTPUT];
   assign FORMAT_CTRL     = mode_reg[ADDR_FORMAT];

   ////////////////////////////////////////////////////////////////////////
   // readback on sdo

   logic                 rd_active_reg, rd_active_next;
   logic [DATA_BITS-1:0] rd_sh_reg, rd_sh_next;
   logic                 sdo_oe_reg, sdo_oe_next;
   logic                 data_phase;

   assign data_phase = (fr_cnt > CNT_HDR) && (fr_cnt < CNT_WORD);

   always_comb begin
      rd_active_next = rd_active_reg;
      rd_sh_next     = rd_sh_reg;
      if (!fr_active) begin
         rd_active_next = 1'b0;
      end else if (fr_hdr && fr_data[HDR_RW_POS]) begin
         // msb is on the pin half an sck period before the ninth rise
         rd_active_next = 1'b1;
         rd_sh_next     = read_mode(fr_data[ADDR_BITS-1:0]);
      end else if (rd_active_reg && link.sck_fall && data_phase) begin
         rd_sh_next = {rd_sh_reg[DATA_BITS-2:0], 1'b1};
      end
      // release after the last bit so the pull-up restores the line
      if (fr_word) begin
         rd_active_next = 1'b0;
      end
      sdo_oe_next = rd_active_next & ~rd_sh_next[DATA_BITS-1];
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         rd_active_reg <= 1'b0;
         rd_sh_reg     <= READ_ZERO;
         sdo_oe_reg    <= 1'b0;
      end else if (CLK_EN) begin
         rd_active_reg <= rd_active_next;
         rd_sh_reg     <= rd_sh_next;
         sdo_oe_reg    <= sdo_oe_next;
      end
   end

   // open drain: the data line itself is a constant low
   assign SDO_O  = 1'b0;
   assign SDO_OE = sdo_oe_reg;

   ////////////////////////////////////////////////////////////////////////
   // mode selection, straps or registers

   logic dcs_reg, dcs_next;
   logic sleep_reg, sleep_next;
   logic nap_reg, nap_next;
   logic lvds_reg, lvds_next;

   always_comb begin
      if (!link.serial_mode) begin
         dcs_next   = link.cs_n;
         sleep_next = link.sck;
         nap_next   = 1'b0;
         lvds_next  = link.sdi;
      end else begin
         dcs_next   = mode_reg[ADDR_TIMING][DCS_BIT];
         sleep_next = mode_reg[ADDR_POWER_DOWN][SLEEP_BIT];
         nap_next   = mode_reg[ADDR_POWER_DOWN][NAP_BIT];
         lvds_next  = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         dcs_reg   <= 1'b0;
         sleep_reg <= 1'b0;
         nap_reg   <= 1'b0;
         lvds_reg  <= 1'b0;
      end else if (CLK_EN) begin
         dcs_reg   <= dcs_next;
         sleep_reg <= sleep_next;
         nap_reg   <= nap_next;
         lvds_reg  <= lvds_next;
      end
   end

   assign DCS_ON           = dcs_reg;
   assign SLEEP_ON         = sleep_reg;
   assign NAP_ON           = nap_reg;
   assign LVDS_LOW_CURRENT = lvds_reg;

endmodule

// [hdl/cfgp_pkg.sv]
package cfgp_pkg;

   // frame layout: flag, seven address bits, eight data bits
   localparam int        WORD_BITS       = 16;
   localparam int        DATA_BITS       = 8;
   localparam int        ADDR_BITS       = 7;
   localparam int        CNT_BITS        = 5;
   localparam logic [CNT_BITS-1:0] CNT_HDR  = 5'h08;
   localparam logic [CNT_BITS-1:0] CNT_WORD = 5'h10;
   localparam int        RW_POS          = 15;
   localparam int        HDR_RW_POS      = 7;

   // register map
   localparam logic [ADDR_BITS-1:0] ADDR_SOFT_RESET = 7'h00;
   localparam logic [ADDR_BITS-1:0] ADDR_POWER_DOWN = 7'h01;
   localparam logic [ADDR_BITS-1:0] ADDR_TIMING     = 7'h02;
   localparam logic [ADDR_BITS-1:0] ADDR_OUTPUT     = 7'h03;
   localparam logic [ADDR_BITS-1:0] ADDR_FORMAT     = 7'h04;
   localparam int        NUM_MODE_REGS   = 5;
   localparam logic [DATA_BITS-1:0] MODE_REG_RESET  = 8'h00;
   localparam logic [DATA_BITS-1:0] READ_ZERO       = 8'h00;

   // field positions
   localparam int        SOFT_RESET_BIT  = 7;
   localparam int        SLEEP_BIT       = 3;
   localparam int        NAP_BIT         = 2;
   localparam int        DCS_BIT         = 0;

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_SHIFT,
      FR_HOLD
   } cfgp_frame_state_t;

endpackage

// [hdl/cfgp_link_if.sv]
`timescale 1ns/1ps

// filtered pin levels and serial clock edges, all on the core clock
interface cfgp_link_if;
   logic serial_mode;
   logic cs_n;
   logic sck;
   logic sdi;
   logic sck_rise;
   logic sck_fall;

   modport src (
      output serial_mode,
      output cs_n,
      output sck,
      output sdi,
      output sck_rise,
      output sck_fall
   );

   modport dst (
      input  serial_mode,
      input  cs_n,
      input  sck,
      input  sdi,
      input  sck_rise,
      input  sck_fall
   );
endinterface

// [hdl/cfgp_sync.sv]
`timescale 1ns/1ps

module cfgp_sync
   import cfgp_pkg::*;
(
   // clock and reset
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire logic    en,
   // raw pins
   input  wire logic    if_sel,
   input  wire logic    cs_n,
   input  wire logic    sck,
   input  wire logic    sdi,
   // filtered view
   cfgp_link_if.src     link
);

   localparam int N = 4;

   logic [N-1:0] pin_in;
   logic [N-1:0] ff1_reg, ff2_reg, ff3_reg, q_reg, q_next;
   logic         rise_reg, rise_next, fall_reg, fall_next;

   assign pin_in = {if_sel, cs_n, sck, sdi};

   // a bit is accepted only once the second and third stages agree
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_filt
         always_comb begin
            q_next[i] = q_reg[i];
            if (ff2_reg[i] == ff3_reg[i]) begin
               q_next[i] = ff3_reg[i];
            end
         end
      end
   endgenerate

   always_comb begin
      rise_next = q_next[1] & ~q_reg[1];
      fall_next = ~q_next[1] & q_reg[1];
   end

   // cs_n and sck idle high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ff1_reg  <= 4'hE;
         ff2_reg  <= 4'hE;
         ff3_reg  <= 4'hE;
         q_reg    <= 4'hE;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else if (en) begin
         ff1_reg  <= pin_in;
         ff2_reg  <= ff1_reg;
         ff3_reg  <= ff2_reg;
         q_reg    <= q_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign link.serial_mode = ~q_reg[3];
   assign link.cs_n        = q_reg[2];
   assign link.sck         = q_reg[1];
   assign link.sdi         = q_reg[0];
   assign link.sck_rise    = rise_reg;
   assign link.sck_fall    = fall_reg;

endmodule

// [hdl/cfgp_frame.sv]
`timescale 1ns/1ps

module cfgp_frame
   import cfgp_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  en,
   // filtered link
   cfgp_link_if.dst                   link,
   // frame results
   output logic                       active,
   output logic                       hdr_stb,
   output logic                       word_stb,
   output logic [CNT_BITS-1:0]        bit_cnt,
   output logic [WORD_BITS-1:0]       word
);

   cfgp_frame_state_t          state_reg, state_next;
   logic [CNT_BITS-1:0]        cnt_reg, cnt_next;
   logic [WORD_BITS-1:0]       sh_reg, sh_next;
   logic                       hdr_reg, hdr_next;
   logic                       word_reg, word_next;
   logic                       stop;

   assign stop = link.cs_n | ~link.serial_mode;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      hdr_next   = 1'b0;
      word_next  = 1'b0;
      case (state_reg)
         FR_IDLE: begin
            cnt_next = '0;
            if (!stop) begin
               state_next = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (stop) begin
               state_next = FR_IDLE;
            end else if (link.sck_rise) begin
               sh_next  = {sh_reg[WORD_BITS-2:0], link.sdi};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == CNT_HDR - 5'h01) begin
                  hdr_next = 1'b1;
               end
               if (cnt_reg == CNT_WORD - 5'h01) begin
                  word_next  = 1'b1;
                  state_next = FR_HOLD;
               end
            end
         end
         FR_HOLD: begin
            // extra rising edges are ignored until cs_n rises
            if (stop) begin
               state_next = FR_IDLE;
            end
         end
         default: state_next = FR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= FR_IDLE;
         cnt_reg   <= '0;
         sh_reg    <= '0;
         hdr_reg   <= 1'b0;
         word_reg  <= 1'b0;
      end else if (en) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         hdr_reg   <= hdr_next;
         word_reg  <= word_next;
      end
   end

   assign active   = (state_reg != FR_IDLE);
   assign hdr_stb  = hdr_reg;
   assign word_stb = word_reg;
   assign bit_cnt  = cnt_reg;
   assign word     = sh_reg;

endmodule

// [verif/cfgp_host_model.sv]
`timescale 1ns/1ps

module cfgp_host_model (
   // serial pins
   output logic      cs_n,
   output logic      sck,
   output logic      sdi,
   // open-drain line after the pull-up
   input  wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b1;
      sdi  = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // one frame of nrise clocks; slow stretches the low phase
   task automatic xfer(input logic [15:0] w, input int nrise,
                       input bit slow, output logic [7:0] rd);
      rd = 8'hFF;
      cs_n = 1'b0;
      #200;
      for (int k = 0; k < nrise; k++) begin
         sck = 1'b0;
         sdi = (k < 16) ? w[15-k] : ~w[0];
         #62.5;
         if (slow) #62.5;
         if (k >= 8 && k < 16) rd[15-k] = sdo;
         sck = 1'b1;
         #62.5;
      end
      #100;
      cs_n = 1'b1;
      // released data line must not keep its last level
      sdi = ~sdi;
      #200;
   endtask
endmodule

// [verif/cfgp_top_asserts.sv]
`timescale 1ns/1ps

module cfgp_top_asserts
   import cfgp_pkg::*;
(
   // clock and reset
   input wire logic                 CORE_CLK,
   input wire logic                 RESET,
   input wire logic                 CLK_EN,
   // pins
   input wire logic                 INTERFACE_SELECT_PIN,
   input wire logic                 CS_N,
   input wire logic                 SCK,
   input wire logic                 SDI,
   input wire logic                 SDO_O,
   input wire logic                 SDO_OE,
   // modes
   input wire logic                 DCS_ON,
   input wire logic                 SLEEP_ON,
   input wire logic                 LVDS_LOW_CURRENT,
   input wire logic [DATA_BITS-1:0] POWER_DOWN_CTRL,
   input wire logic [DATA_BITS-1:0] TIMING_CTRL
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   ////////////////////////////////////////////////////////////
   a_sdo_pull_low: assert property (SDO_O == 1'b0)
      else $error("sdo data level not low");
   a_strap_quiet: assert property (
      INTERFACE_SELECT_PIN [*8] |-> !SDO_OE)
      else $error("sdo driven in strap mode");
   a_strap_dcs: assert property (
      (CLK_EN && INTERFACE_SELECT_PIN && $stable(CS_N)) [*8]
      |-> DCS_ON == CS_N)
      else $error("stabilizer does not follow strap");
   a_strap_sleep: assert property (
      (CLK_EN && INTERFACE_SELECT_PIN && $stable(SCK)) [*8]
      |-> SLEEP_ON == SCK)
      else $error("sleep does not follow strap");
   a_strap_lvds: assert property (
      (CLK_EN && INTERFACE_SELECT_PIN && $stable(SDI)) [*8]
      |-> LVDS_LOW_CURRENT == SDI)
      else $error("drive current does not follow strap");
   a_oe_idle: assert property (CS_N [*8] |-> !SDO_OE)
      else $error("sdo driven outside a frame");
   a_oe_in_frame: assert property (
      $rose(SDO_OE) |-> !CS_N && !INTERFACE_SELECT_PIN)
      else $error("sdo driven without serial frame");
   a_regs_hold: assert property (
      (CS_N && !INTERFACE_SELECT_PIN) [*8]
      |=> $stable(POWER_DOWN_CTRL) && $stable(TIMING_CTRL))
      else $error("register changed between frames");
   a_dcs_serial: assert property (
      (!INTERFACE_SELECT_PIN && $stable(TIMING_CTRL)) [*8]
      |-> DCS_ON == TIMING_CTRL[DCS_BIT])
      else $error("stabilizer does not follow register");

   c_readback: cover property ($rose(SDO_OE));
   c_cleared: cover property ($fell(|POWER_DOWN_CTRL));
   c_strap_sleep: cover property ($rose(SLEEP_ON) && INTERFACE_SELECT_PIN);
endmodule

// [verif/tb_adc_mode_config_port.sv]
`timescale 1ns/1ps

module tb_adc_mode_config_port;
   import cfgp_pkg::*;
   logic                 core_clk = 1'b0;
   logic                 reset = 1'b1;
   logic                 clk_en = 1'b1;
   logic                 sel = 1'b1;
   logic                 s_cs = 1'b1;
   logic                 s_sck = 1'b0;
   logic                 s_sdi = 1'b0;
   logic                 h_cs_n, h_sck, h_sdi;
   logic                 sdo_o, sdo_oe, dcs_on, sleep_on, nap_on, lvds_low;
   logic [DATA_BITS-1:0] pd_ctrl, tim_ctrl, out_ctrl, fmt_ctrl;
   wire  logic           sdo_line = sdo_oe ? sdo_o : 1'b1;
   int                   num_errors = 0;
   int                   total_checks = 0;
   int                   seed = 52448;
   int                   model [1:4];
   logic [7:0]           rd, d;
   logic [31:0]          v;
   int                   i;

   always #5 core_clk = ~core_clk;

   cfgp_host_model u_host (.cs_n(h_cs_n), .sck(h_sck), .sdi(h_sdi),
                           .sdo(sdo_line));

   cfgp_top u_dut (
      .CORE_CLK(core_clk), .RESET(reset), .CLK_EN(clk_en),
      .INTERFACE_SELECT_PIN(sel),
      .CS_N(sel ? s_cs : h_cs_n), .SCK(sel ? s_sck : h_sck),
      .SDI(sel ? s_sdi : h_sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
      .DCS_ON(dcs_on), .SLEEP_ON(sleep_on), .NAP_ON(nap_on),
      .LVDS_LOW_CURRENT(lvds_low), .POWER_DOWN_CTRL(pd_ctrl),
      .TIMING_CTRL(tim_ctrl), .OUTPUT_CTRL(out_ctrl),
      .FORMAT_CTRL(fmt_ctrl));

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk_regs;
      check(pd_ctrl, 8'(model[1]));
      check(tim_ctrl, 8'(model[2]));
      check(out_ctrl, 8'(model[3]));
      check(fmt_ctrl, 8'(model[4]));
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] dt);
      u_host.xfer({1'b0, a, dt}, 16, 1'b0, rd);
      if (a == 7'h00 && dt[7]) model = '{0, 0, 0, 0};
      else if (a >= 7'h01 && a <= 7'h04) model[a] = int'(dt);
   endtask

   // sdi data bits are random and must be ignored
   task automatic rd_chk(input logic [6:0] a);
      logic [7:0] junk;
      junk = 8'($random(seed));
      u_host.xfer({1'b1, a, junk}, 16, 1'b1, rd);
      check(rd, (a >= 7'h01 && a <= 7'h04) ? 8'(model[a]) : 8'h00);
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      model = '{0, 0, 0, 0};
      repeat (10) @(posedge core_clk);
      #1 reset = 1'b0;
      v = $random(seed);
      for (i = 0; i < 8; i++) begin
         {s_cs, s_sck, s_sdi} = 3'(i) ^ v[2:0];
         repeat (8) @(posedge core_clk);
         #1;
         check({7'h00, dcs_on}, {7'h00, s_cs});
         check({7'h00, sleep_on}, {7'h00, s_sck});
         check({7'h00, lvds_low}, {7'h00, s_sdi});
         check({7'h00, sdo_oe | nap_on}, 8'h00);
      end
      // enable low: straps move but dcs_on, sleep_on and lvds_low must hold their old values
      clk_en = 1'b0;
      v = {29'h0, s_cs, s_sck, s_sdi};
      {s_cs, s_sck, s_sdi} = ~v[2:0];
      repeat (8) @(posedge core_clk);
      #1 check({5'h00, dcs_on, sleep_on, lvds_low}, v[7:0]);
      clk_en = 1'b1;
      repeat (8) @(posedge core_clk);
      #1 check({5'h00, dcs_on, sleep_on, lvds_low}, {5'h00, ~v[2:0]});
      $display("strap test done");
      sel = 1'b0;
      repeat (10) @(posedge core_clk);
      #1;
      wr(7'h00, 8'h80);
      chk_regs();
      for (i = 1; i <= 4; i++) begin
         wr(7'(i), 8'($random(seed)));
         chk_regs();
         rd_chk(7'(i));
         chk_regs();
      end
      check({7'h00, dcs_on}, {7'h00, 1'(model[2])});
      check({7'h00, sleep_on}, {7'h00, 1'(model[1] >> SLEEP_BIT)});
      check({7'h00, nap_on}, {7'h00, 1'(model[1] >> NAP_BIT)});
      wr(7'h00, 8'h7F);
      chk_regs();
      rd_chk(7'h00);
      wr(7'h05, 8'hA5);
      chk_regs();
      rd_chk(7'h05);
      $display("register test done");
      d = 8'($random(seed));
      u_host.xfer({1'b0, 7'h03, d}, 20, 1'b0, rd);
      model[3] = int'(d);
      chk_regs();
      u_host.xfer({1'b0, 7'h03, ~d}, 10, 1'b0, rd);
      chk_regs();
      $display("frame test done");
      wr(7'h00, 8'h80);
      chk_regs();
      wr(7'h01, 8'h0C);
      chk_regs();
      $display("soft reset test done");
      print_verdict();
   end

   initial begin
      #200000;
      num_errors++;
      $display("ERROR at %0t: run did not finish", $time);
      print_verdict();
   end
endmodule

bind cfgp_top cfgp_top_asserts u_chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
   .INTERFACE_SELECT_PIN(INTERFACE_SELECT_PIN),
   .CS_N(CS_N), .SCK(SCK), .SDI(SDI), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
   .DCS_ON(DCS_ON), .SLEEP_ON(SLEEP_ON),
   .LVDS_LOW_CURRENT(LVDS_LOW_CURRENT),
   .POWER_DOWN_CTRL(POWER_DOWN_CTRL), .TIMING_CTRL(TIMING_CTRL));
